// ===== core/bbc_pkg.sv
package bbc_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] BBC_OFS_CODE_LOW = 8'h03;
  localparam logic [7:0] BBC_OFS_CONTROL = 8'h04;
  localparam logic [7:0] BBC_OFS_IRQ_EN1 = 8'h05;
  // ==========================================
  // Reset values
  localparam logic [7:0] BBC_RST_CODE_LOW = 8'h7D;
  localparam logic [7:0] BBC_RST_CONTROL = 8'h04;
  localparam logic [7:0] BBC_RST_IRQ_EN1 = 8'h7F;
  // ==========================================
  // Enable register layout
  localparam logic [7:0] BBC_IRQ_EN_RW_MASK = 8'h7C;
  localparam logic [7:0] BBC_IRQ_EN_RO_VAL = 8'h03;
  localparam int BBC_MEAS_DONE_BIT = 1;
  localparam int BBC_COMMIT_DONE_BIT = 0;
  localparam int BBC_FAULT_LSB = 2;
  localparam int BBC_FAULT_W = 5;
  // ==========================================
  // Widths
  localparam int BBC_CODE_W = 9;
  localparam int BBC_SUM_W = 12;
  localparam int BBC_CNT_W = 4;

  typedef struct packed {
    logic measure_start;
    logic nv_commit;
    logic output_float;
    logic [1:0] average_count;
    logic spare_hi;
    logic spare_lo;
    logic code_msb;
  } bbc_ctl_t;

  typedef struct packed {
    logic measure_done_flag;
    logic commit_done_flag;
  } bbc_flags_t;

  typedef enum logic [2:0] {
    BBC_IDLE = 3'b001,
    BBC_MEASURE = 3'b010,
    BBC_COMMIT = 3'b100
  } bbc_state_t;
endpackage

// ===== core/bbc_regs.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Nine-bit bias code split across two registers
// R2: Bias output equals code times minus 10 mV
// R3: Low code register resets to 7Dh
// R4: Measure bit starts acquisition, self-clears, loads code
// R5: Average field selects 1, 2, 4, 8 conversions
// R6: Commit bit stores code, self-clears, requests standby
// R7: Float bit puts bias pin high impedance
// R8: Control resets 04h, spare bits plain storage
// R9: Enabled events pull interrupt output low
// R10: Temperature-change enable read-only, resets zero
// R11: Bits 6..2 writable enables resetting one
// R12: Measure-done enable read-only, resets one
// R13: Enable register reads 7Fh after reset
// R14: Commit-done enable read-only, resets one
// R15: Finished measurement sets measure-done flag
// R16: Finished commit sets commit-done flag
// R17: Host waits for completion before next command
module bbc_regs import bbc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port from serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Bias amplifier and converter
  output logic [8:0] bias_dac_code,
  output logic output_float,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [8:0] adc_code,
  // Nonvolatile store
  output logic nv_write,
  output logic [8:0] nv_data,
  input wire logic nv_done,
  output logic standby_req,
  // Interrupts
  input wire logic [4:0] fault_evt,
  input wire logic [1:0] flag_clear,
  output logic [1:0] done_flags,
  output logic irq_out_n
);
  // ==========================================
  // Fault input synchroniser
  logic [4:0] fault_m, fault_s;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fault_m <= '0;
      fault_s <= '0;
    end else begin
      fault_m <= fault_evt;
      fault_s <= fault_m;
    end
  end

  // ==========================================
  // Register state and sequencer
  bbc_state_t state, next_state;
  bbc_ctl_t ctl, next_ctl;
  bbc_flags_t flags, next_flags;
  logic [7:0] code_low, next_code_low;
  logic [7:0] irq_en, next_irq_en;
  logic [BBC_SUM_W-1:0] acc, next_acc;
  logic [BBC_CNT_W-1:0] left, next_left;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic start_p, next_start_p;
  logic nvw_p, next_nvw_p;
  logic stby_p, next_stby_p;
  logic irq_n, next_irq_n;
  logic [BBC_SUM_W-1:0] sum_now, avg_now;
  logic [7:0] pending;
  bbc_ctl_t wr_ctl;

  always_comb begin
    next_state = state;
    next_ctl = ctl;
    next_flags = flags;
    next_code_low = code_low;
    next_irq_en = irq_en;
    next_acc = acc;
    next_left = left;
    next_rdata = rdata;
    next_rvalid = reg_rd;
    next_start_p = 1'b0;
    next_nvw_p = 1'b0;
    next_stby_p = 1'b0;
    wr_ctl = bbc_ctl_t'(reg_wdata);
    sum_now = acc + BBC_SUM_W'(adc_code);
    avg_now = sum_now >> ctl.average_count;
    if (reg_rd) begin
      unique case (reg_addr)
        BBC_OFS_CODE_LOW: next_rdata = code_low; // R1
        BBC_OFS_CONTROL: next_rdata = ctl; // R1
        BBC_OFS_IRQ_EN1: next_rdata = irq_en; // R13
        default: next_rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        BBC_OFS_CODE_LOW: next_code_low = reg_wdata; // R1
        BBC_OFS_CONTROL: begin
          // Command bits not written here; only the sequencer sets and clears them
          next_ctl.output_float = wr_ctl.output_float; // R7
          next_ctl.average_count = wr_ctl.average_count; // R5
          next_ctl.spare_hi = wr_ctl.spare_hi; // R8
          next_ctl.spare_lo = wr_ctl.spare_lo; // R8
          next_ctl.code_msb = wr_ctl.code_msb; // R1
        end
        BBC_OFS_IRQ_EN1: begin
          next_irq_en = (reg_wdata & BBC_IRQ_EN_RW_MASK) | BBC_IRQ_EN_RO_VAL; // R10 R11 R12 R14
        end
        default: ;
      endcase
    end
    // Clear first so a completing event in the same cycle wins
    if (flag_clear[BBC_MEAS_DONE_BIT]) next_flags.measure_done_flag = 1'b0;
    if (flag_clear[BBC_COMMIT_DONE_BIT]) next_flags.commit_done_flag = 1'b0;
    unique case (state)
      BBC_IDLE: begin
        if (reg_wr && reg_addr == BBC_OFS_CONTROL && wr_ctl.measure_start) begin
          next_ctl.measure_start = 1'b1; // R4
          next_acc = '0;
          // Count from the field written with the start bit, not the old one
          next_left = BBC_CNT_W'(1) << wr_ctl.average_count; // R5
          next_start_p = 1'b1;
          next_state = BBC_MEASURE;
        end else if (reg_wr && reg_addr == BBC_OFS_CONTROL && wr_ctl.nv_commit) begin
          next_ctl.nv_commit = 1'b1; // R6
          next_nvw_p = 1'b1;
          next_state = BBC_COMMIT;
        end
      end
      BBC_MEASURE: begin
        if (adc_done) begin
          next_acc = sum_now;
          next_left = left - BBC_CNT_W'(1);
          if (left == BBC_CNT_W'(1)) begin
            next_code_low = avg_now[7:0]; // R4 R5
            next_ctl.code_msb = avg_now[8];
            next_ctl.measure_start = 1'b0; // R4
            next_flags.measure_done_flag = 1'b1; // R15
            next_state = BBC_IDLE;
          end else begin
            next_start_p = 1'b1; // R5
          end
        end
      end
      BBC_COMMIT: begin
        if (nv_done) begin
          next_ctl.nv_commit = 1'b0; // R6
          next_flags.commit_done_flag = 1'b1; // R16
          next_stby_p = 1'b1; // R6
          next_state = BBC_IDLE;
        end
      end
    endcase
    pending = {1'b0, fault_s, flags};
    next_irq_n = ~|(pending & irq_en); // R9
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= BBC_IDLE;
      ctl <= bbc_ctl_t'(BBC_RST_CONTROL); // R8
      flags <= '0;
      code_low <= BBC_RST_CODE_LOW; // R3
      irq_en <= BBC_RST_IRQ_EN1; // R13
      acc <= '0;
      left <= '0;
      rdata <= '0;
      rvalid <= 1'b0;
      start_p <= 1'b0;
      nvw_p <= 1'b0;
      stby_p <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      flags <= next_flags;
      code_low <= next_code_low;
      irq_en <= next_irq_en;
      acc <= next_acc;
      left <= next_left;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      start_p <= next_start_p;
      nvw_p <= next_nvw_p;
      stby_p <= next_stby_p;
      irq_n <= next_irq_n;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = rdata;
  assign reg_rvalid = rvalid;
  assign bias_dac_code = {ctl.code_msb, code_low}; // R2
  assign output_float = ctl.output_float; // R7
  assign adc_start = start_p;
  assign nv_write = nvw_p;
  assign nv_data = {ctl.code_msb, code_low}; // R6
  assign standby_req = stby_p;
  assign done_flags = flags;
  assign irq_out_n = irq_n;

  // ==========================================
  // Checks
  a_code_low_reset: assert property (@(posedge sys_clk) // R3
    $rose(nrst) |-> code_low == BBC_RST_CODE_LOW)
    else $error("low code not 7Dh after reset");
  a_ctl_reset: assert property (@(posedge sys_clk) // R8
    $rose(nrst) |-> ctl == bbc_ctl_t'(BBC_RST_CONTROL))
    else $error("control not 04h after reset");
  a_en_reset: assert property (@(posedge sys_clk) // R13
    $rose(nrst) |-> irq_en == BBC_RST_IRQ_EN1)
    else $error("enable not 7Fh after reset");
  a_en_ro_bits: assert property (@(posedge sys_clk) disable iff (!nrst) // R10 R12 R14
    (irq_en & ~BBC_IRQ_EN_RW_MASK) == BBC_IRQ_EN_RO_VAL)
    else $error("read-only enable bits changed");
  a_meas_start: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
    state == BBC_IDLE && reg_wr && reg_addr == BBC_OFS_CONTROL && wr_ctl.measure_start
    |=> adc_start && ctl.measure_start)
    else $error("measure write did not start conversion");
  a_meas_done: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
    state == BBC_MEASURE && adc_done && left == BBC_CNT_W'(1)
    |=> !ctl.measure_start && flags.measure_done_flag && state == BBC_IDLE)
    else $error("measure completion not reflected");
  a_avg_count: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
    $rose(state == BBC_MEASURE) |-> left == (BBC_CNT_W'(1) << ctl.average_count))
    else $error("conversion count wrong");
  a_commit_end: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
    state == BBC_COMMIT && nv_done
    |=> standby_req && !ctl.nv_commit && flags.commit_done_flag)
    else $error("commit completion wrong");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
    ##1 irq_out_n == !$past(|({1'b0, fault_s, flags} & irq_en)))
    else $error("interrupt output mismatch");
  a_float_follow: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
    reg_wr && reg_addr == BBC_OFS_CONTROL |=> output_float == $past(wr_ctl.output_float))
    else $error("float bit not applied");
endmodule

// ===== verif/bbc_far_model.sv
`timescale 1ns/1ps
module bbc_far_model #(
  parameter logic [8:0] BASE = 9'h010
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Converter side
  input wire logic adc_start,
  input wire logic [3:0] lat,
  output logic adc_done,
  output logic [8:0] adc_code,
  // Store side
  input wire logic nv_write,
  input wire logic [8:0] nv_data,
  output logic nv_done,
  output logic [8:0] stored
);
  // ==========================================
  // Delayed answers
  logic [4:0] cnt;
  logic nv_op;
  logic [8:0] k;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {cnt, nv_op, k, adc_done, nv_done, adc_code, stored} <= '0;
    end else begin
      adc_done <= 1'b0;
      nv_done <= 1'b0;
      // Code is valid only in the done cycle
      adc_code <= ~adc_code;
      if (adc_start || nv_write) begin
        cnt <= {1'b0, lat} + 5'h01;
        nv_op <= nv_write;
        if (nv_write) stored <= nv_data;
      end else if (cnt == 5'h01) begin
        cnt <= 5'h00;
        if (nv_op) nv_done <= 1'b1;
        else begin
          adc_done <= 1'b1;
          adc_code <= BASE + k;
          k <= k + 9'h001;
        end
      end else if (cnt != 5'h00) cnt <= cnt - 5'h01;
    end
  end
endmodule

// ===== verif/test_backplane_bias_ctrl_regs.sv
`timescale 1ns/1ps
module test_backplane_bias_ctrl_regs;
  import bbc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid, output_float, adc_start, adc_done, nv_write, nv_done, standby_req, irq_out_n;
  logic [8:0] bias_dac_code, adc_code, nv_data, stored;
  logic [3:0] lat = 4'h0;
  logic [4:0] fault_evt = 5'h00;
  logic [1:0] flag_clear = 2'b00;
  logic [1:0] done_flags;
  int bad_count = 0;
  int n_checks = 0;
  int n_conv = 0;
  int n_stby = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (adc_done === 1'b1) n_conv <= n_conv + 1;
    if (standby_req === 1'b1) n_stby <= n_stby + 1;
  end
  bbc_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .bias_dac_code(bias_dac_code), .output_float(output_float),
    .adc_start(adc_start), .adc_done(adc_done), .adc_code(adc_code), .nv_write(nv_write),
    .nv_data(nv_data), .nv_done(nv_done), .standby_req(standby_req), .fault_evt(fault_evt),
    .flag_clear(flag_clear), .done_flags(done_flags), .irq_out_n(irq_out_n));
  bbc_far_model far_u (.sys_clk(sys_clk), .nrst(nrst), .adc_start(adc_start), .lat(lat),
    .adc_done(adc_done), .adc_code(adc_code), .nv_write(nv_write), .nv_data(nv_data),
    .nv_done(nv_done), .stored(stored));
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rvalid", 9'h001, {8'h00, reg_rvalid});
    chk("rdata", {1'b0, exp}, {1'b0, reg_rdata});
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (done_flags[b] !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk("done_flag", 9'h001, {8'h00, done_flags[b]});
    @(negedge sys_clk);
  endtask
  task automatic pulse_clear();
    @(negedge sys_clk);
    flag_clear = 2'b11;
    @(negedge sys_clk);
    flag_clear = 2'b00;
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(BBC_OFS_CODE_LOW, 8'h7D);
    rd(BBC_OFS_CONTROL, 8'h04);
    rd(BBC_OFS_IRQ_EN1, 8'h7F);
    rd(8'h06, 8'h00);
    chk("code", 9'h07D, bias_dac_code);
    chk("irq", 9'h001, {8'h00, irq_out_n});
  endtask
  task automatic t_regs();
    wr(BBC_OFS_IRQ_EN1, 8'h00);
    rd(BBC_OFS_IRQ_EN1, 8'h03);
    wr(BBC_OFS_IRQ_EN1, 8'hFF);
    rd(BBC_OFS_IRQ_EN1, 8'h7F);
    wr(BBC_OFS_CODE_LOW, 8'h23);
    wr(BBC_OFS_CONTROL, 8'h23);
    rd(BBC_OFS_CONTROL, 8'h23);
    chk("code", 9'h123, bias_dac_code);
    chk("float", 9'h001, {8'h00, output_float});
    wr(BBC_OFS_CONTROL, 8'h04);
    chk("float", 9'h000, {8'h00, output_float});
    wr(8'h07, 8'hAA);
    rd(BBC_OFS_CODE_LOW, 8'h23);
  endtask
  task automatic t_measure();
    int k0;
    int sum;
    for (int a = 0; a < 4; a++) begin
      pulse_clear();
      lat = 4'(a * 5);
      k0 = n_conv;
      sum = 0;
      for (int i = 0; i < (1 << a); i++) sum += 16 + k0 + i;
      wr(BBC_OFS_CONTROL, {3'b100, 2'(a), 3'b100});
      wait_flag(1);
      chk("convs", 9'(1 << a), 9'(n_conv - k0));
      chk("code", 9'(sum >> a), bias_dac_code);
      chk("flags", 9'h002, {7'h00, done_flags});
      rd(BBC_OFS_CONTROL, {3'b000, 2'(a), 3'b100});
      chk("irq", 9'h000, {8'h00, irq_out_n});
    end
  endtask
  task automatic t_commit();
    pulse_clear();
    wr(BBC_OFS_CODE_LOW, 8'h5A);
    wr(BBC_OFS_CONTROL, 8'h45);
    wait_flag(0);
    chk("stored", 9'h15A, stored);
    chk("stby", 9'h001, 9'(n_stby));
    chk("flags", 9'h001, {7'h00, done_flags});
    rd(BBC_OFS_CONTROL, 8'h05);
    chk("irq", 9'h000, {8'h00, irq_out_n});
  endtask
  task automatic t_irq();
    pulse_clear();
    for (int i = 0; i < 5; i++) begin
      wr(BBC_OFS_IRQ_EN1, 8'h7C & ~(8'h04 << i));
      fault_evt = 5'(1 << i);
      repeat (5) @(negedge sys_clk);
      chk("masked", 9'h001, {8'h00, irq_out_n});
      wr(BBC_OFS_IRQ_EN1, 8'h04 << i);
      repeat (4) @(negedge sys_clk);
      chk("unmasked", 9'h000, {8'h00, irq_out_n});
      fault_evt = 5'h00;
    end
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_measure();
    t_commit();
    t_irq();
    stop_test();
  end
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule
